//--- src/pmt_pkg.sv
/*
  package for the program memory and table read block: register map,
  field layouts, reset values, timing counts and carrier structs.
  assumes a 32-bit classic wishbone slave port and a 250 MHz clock.
*/
package pmt_pkg;

  // ==========================================================
  // memory geometry
  localparam int PMT_WORDS = 1024;
  localparam int PMT_WORD_W = 16;
  localparam int PMT_ADDR_W = 10;
  localparam int PMT_PAGE_W = 8;
  localparam logic [9:0] PMT_RESET_VECTOR = 10'h000;
  localparam logic [1:0] PMT_LAST_PAGE = 2'h3;

  // ==========================================================
  // timing: one instruction cycle is four system clocks (T1..T4)
  localparam int PMT_CLOCK_MHZ = 250;
  localparam int PMT_PHASES = 4;
  localparam logic [1:0] PMT_PHASE_LAST = 2'(PMT_PHASES - 1);
  localparam int PMT_TABLE_CYCLES = 2;
  localparam logic [1:0] PMT_TABLE_LAST = 2'(PMT_TABLE_CYCLES - 1);

  // ==========================================================
  // serial frame: command bit, address, data word
  localparam int PMT_FRAME_BITS = 1 + PMT_ADDR_W + PMT_WORD_W;
  localparam logic [4:0] PMT_FRAME_LAST = 5'(PMT_FRAME_BITS - 1);
  localparam logic [4:0] PMT_HDR_LAST = 5'(PMT_ADDR_W);
  localparam logic PMT_CMD_WRITE = 1'b1;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PMT_REG_PTR_LOW = 8'h00;
  localparam logic [7:0] PMT_REG_PTR_HIGH = 8'h04;
  localparam logic [7:0] PMT_REG_TBL_HIGH = 8'h08;
  localparam logic [7:0] PMT_REG_PC_LOW = 8'h0c;
  localparam logic [7:0] PMT_REG_PC_HIGH = 8'h10;
  localparam logic [7:0] PMT_REG_STATUS = 8'h14;

  // status fields
  localparam int PMT_ST_BUSY = 0;
  localparam int PMT_ST_PROG = 1;
  localparam int PMT_ST_DEBUG = 2;

  // reset values
  localparam logic [7:0] PMT_PTR_RESET = 8'h00;
  localparam logic [7:0] PMT_TABLE_HIGH_BYTE_RESET = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic lastPage;
    logic [7:0] dest;
  } pmt_tblreq_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } pmt_dmwr_t;

endpackage

//--- src/pmt_prog_mem.sv
/*
  program memory of the core with table read engine, program counter,
  wishbone register port and two serial access ports (programming and debug).
  assumes the core samples fetches on instrTick and stalls while tableBusy.
*/
// The address map and the Wishbone register port were decided locally.
// How it works
// - 1024 words of 16 bits, fetched by pc
// - reset starts fetching at word zero
// - table pointer low/high bytes address any word
// - table read writes low byte to operand
// - table read puts high byte in register
// - unbacked high bits read back as zero
// - table high byte register ignores bus writes
// - table instructions last exactly two instruction cycles
// - full variant uses both pointer bytes
// - serial data line shared, clock from programmer
// - debug port: two-way data, input-only clock
// - ten-bit pc: two high bits, low byte
`timescale 1ns/100ps
`default_nettype none

module pmt_prog_mem
  import pmt_pkg::*;
#(
  parameter int WORD_W = pmt_pkg::PMT_WORD_W
) (
  input wire logic clock,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  output logic instrTick,
  output logic [15:0] instrWord,
  output logic [9:0] pcValue,
  input wire logic jumpReq,
  input wire logic [9:0] jumpTarget,
  input wire pmt_pkg::pmt_tblreq_t tableReq,
  output logic tableBusy,
  output pmt_pkg::pmt_dmwr_t dataWrite,
  output logic [7:0] tableHighByte,
  // in-circuit programming pins
  input wire logic progEnable,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_n,
  // on-chip debug pins
  input wire logic debugEnable,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_data_in,
  output logic debug_serial_data_out,
  output logic debug_serial_data_oe_n
);
  import pmt_pkg::*;

  // ==========================================================
  // storage
  // program word array
  logic [WORD_W-1:0] mem [PMT_WORDS];

  // ==========================================================
  // instruction cycle divider
  logic [1:0] phase;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  wire logic tick = (phase == PMT_PHASE_LAST);
  assign instrTick = tick;

  // ==========================================================
  // bus decode
  wire logic busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic busWr = busReq && wb_we_i && wb_sel_i[0];
  wire logic wrPtrLow = busWr && (wb_adr_i == PMT_REG_PTR_LOW);
  wire logic wrPtrHigh = busWr && (wb_adr_i == PMT_REG_PTR_HIGH);
  wire logic wrPcLow = busWr && (wb_adr_i == PMT_REG_PC_LOW);

  // ==========================================================
  // table pointer
  logic [7:0] ptrLow;
  logic [7:0] ptrHigh;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ptrLow <= PMT_PTR_RESET;
      ptrHigh <= PMT_PTR_RESET;
    end else begin
      if (wrPtrLow) begin
        ptrLow <= wb_dat_i[7:0];
      end
      if (wrPtrHigh) begin
        ptrHigh <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // table read engine
  logic busy;
  logic [1:0] tblCount;
  logic tblLast;
  logic [7:0] tblDest;
  logic [9:0] tblAddr;
  wire logic tblStart = tick && tableReq.valid && !busy;
  // full variant takes page from high byte
  wire logic [1:0] tblPage = tableReq.lastPage ? PMT_LAST_PAGE : ptrHigh[1:0];
  wire logic [9:0] next_tblAddr = {tblPage, ptrLow};
  wire logic tblDone = tick && busy && (tblCount == PMT_TABLE_LAST);
  // zero-extend the stored word to sixteen bits
  wire logic [15:0] tblWord = 16'(mem[tblAddr]);
  assign tableBusy = busy;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy <= 1'b0;
      tblCount <= 2'h0;
      tblLast <= 1'b0;
      tblDest <= 8'h00;
      tblAddr <= 10'h000;
    end else if (tblStart) begin
      busy <= 1'b1;
      tblCount <= 2'h0;
      tblLast <= tableReq.lastPage;
      tblDest <= tableReq.dest;
      tblAddr <= next_tblAddr;
    end else if (tblDone) begin
      busy <= 1'b0;
    end else if (tick && busy) begin
      tblCount <= tblCount + 2'h1;
    end
  end

  // low byte goes to the operand register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dataWrite <= '0;
      tableHighByte <= PMT_TABLE_HIGH_BYTE_RESET;
    end else begin
      dataWrite.valid <= tblDone;
      if (tblDone) begin
        dataWrite.addr <= tblDest;
        dataWrite.data <= tblWord[7:0];
        tableHighByte <= tblWord[15:8];
      end
    end
  end

  // ==========================================================
  // program counter and fetch
  logic [9:0] pc;
  logic [9:0] next_pc;
  // ten bits, low byte writable by software
  assign next_pc = jumpReq ? jumpTarget : pc + 10'h001;
  assign pcValue = pc;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc <= PMT_RESET_VECTOR;
    end else if (wrPcLow) begin
      pc <= {pc[9:8], wb_dat_i[7:0]};
    end else if (tick && !busy) begin
      pc <= next_pc;
    end
  end

  // both busy table cycles hold the fetch so the core sees no new word
  always_ff @(posedge clock) begin
    if (!nrst) begin
      instrWord <= 16'h0000;
    end else if (tick && !busy) begin
      instrWord <= 16'(mem[pc]);
    end
  end

  // ==========================================================
  // serial access ports, index 0 programming, 1 debug
  // one shared data line, clock from programmer
  logic [1:0] serEnable;
  logic [1:0] serClk;
  logic [1:0] serIn;
  logic [1:0] serOut;
  logic [1:0] serOeN;
  logic [1:0] serWrite;
  logic [9:0] serAddr [2];
  logic [WORD_W-1:0] serData [2];

  assign serEnable = {debugEnable, progEnable};
  assign serClk = {debug_serial_clock, prog_serial_clock};
  assign serIn = {debug_serial_data_in, prog_serial_data_in};
  assign prog_serial_data_out = serOut[0];
  assign prog_serial_data_oe_n = serOeN[0];
  assign debug_serial_data_out = serOut[1];
  assign debug_serial_data_oe_n = serOeN[1];

  for (genvar g = 0; g < 2; g++) begin : gSer
    logic clkPrev;
    logic [4:0] bitCount;
    logic [PMT_FRAME_BITS-1:0] shiftIn;
    logic [15:0] shiftOut;
    logic reading;
    wire logic rise = serClk[g] && !clkPrev;
    wire logic fall = !serClk[g] && clkPrev;
    wire logic [PMT_FRAME_BITS-1:0] next_shiftIn = {shiftIn[PMT_FRAME_BITS-2:0], serIn[g]};
    wire logic hdrDone = rise && (bitCount == PMT_HDR_LAST);
    wire logic isWrite = next_shiftIn[PMT_ADDR_W] == PMT_CMD_WRITE;
    wire logic frameDone = rise && (bitCount == PMT_FRAME_LAST);

    always_ff @(posedge clock) begin
      if (!nrst || !serEnable[g]) begin
        clkPrev <= 1'b0;
        bitCount <= 5'h00;
        shiftIn <= '0;
        shiftOut <= 16'h0000;
        reading <= 1'b0;
      end else begin
        clkPrev <= serClk[g];
        if (rise) begin
          shiftIn <= next_shiftIn;
          bitCount <= frameDone ? 5'h00 : bitCount + 5'h01;
        end
        if (hdrDone) begin
          reading <= !isWrite;
          shiftOut <= 16'(mem[next_shiftIn[PMT_ADDR_W-1:0]]);
        end else if (frameDone) begin
          reading <= 1'b0;
        end else if (fall && reading) begin
          shiftOut <= {shiftOut[14:0], 1'b0};
        end
      end
    end

    // device drives only in the read half; low enable means driving
    assign serOut[g] = shiftOut[15];
    assign serOeN[g] = !reading;
    // write frame assumes programmer owns both lines
    assign serWrite[g] = frameDone && (next_shiftIn[PMT_FRAME_BITS-1] == PMT_CMD_WRITE);
    assign serAddr[g] = next_shiftIn[PMT_FRAME_BITS-2 -: PMT_ADDR_W];
    assign serData[g] = WORD_W'(next_shiftIn[15:0]);
  end

  // programming port wins if both ports write in one clock
  wire logic memWe = serWrite[0] || serWrite[1];
  wire logic [9:0] memWa = serWrite[0] ? serAddr[0] : serAddr[1];
  wire logic [WORD_W-1:0] memWd = serWrite[0] ? serData[0] : serData[1];

  // storage written only through serial access
  always_ff @(posedge clock) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // ==========================================================
  // bus read and acknowledge
  // the high byte register has no write path
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (wb_adr_i)
      PMT_REG_PTR_LOW: rdMux[7:0] = ptrLow;
      PMT_REG_PTR_HIGH: rdMux[7:0] = ptrHigh;
      PMT_REG_TBL_HIGH: rdMux[7:0] = tableHighByte;
      PMT_REG_PC_LOW: rdMux[7:0] = pc[7:0];
      PMT_REG_PC_HIGH: rdMux[1:0] = pc[9:8];
      PMT_REG_STATUS: begin
        rdMux[PMT_ST_BUSY] = busy;
        rdMux[PMT_ST_PROG] = progEnable;
        rdMux[PMT_ST_DEBUG] = debugEnable;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= rdMux;
      end
    end
  end

  // tblLast is not read anywhere; it only feeds the unused wire unusedLast
  wire logic unusedLast = tblLast;

endmodule

`default_nettype wire

//--- dv/pmt_monitor.sv
/* checker: table read timing, pc, pins.
   assumes a bind into pmt_prog_mem. */
`timescale 1ns/100ps
`default_nettype none
module pmt_monitor
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic instrTick,
  input wire logic [9:0] pcValue,
  input wire logic jumpReq,
  input wire pmt_pkg::pmt_tblreq_t tableReq,
  input wire logic tableBusy,
  input wire pmt_pkg::pmt_dmwr_t dataWrite,
  input wire logic [7:0] tableHighByte,
  input wire logic progEnable,
  input wire logic prog_serial_data_oe_n
);
  import pmt_pkg::*;
  // ==========
  // helpers
  wire logic busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic pcWr = busReq && wb_we_i && wb_adr_i == PMT_REG_PC_LOW;
  wire logic thbRd = busReq && !wb_we_i && wb_adr_i == PMT_REG_TBL_HIGH;
  // the pc steps once more on the taking tick before the stall; that tick is left out
  wire logic fetch = instrTick && !tableBusy && !jumpReq && !pcWr && !tableReq.valid;
  wire logic taken = instrTick && tableReq.valid && !tableBusy;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========
  // properties
  property p_rst; $rose(nrst) |-> pcValue == PMT_RESET_VECTOR; endproperty
  a_rst: assert property (p_rst) else $error("pc not zero after reset");
  property p_busy; $rose(tableBusy) |-> tableBusy [*8] ##1 (!tableBusy && dataWrite.valid); endproperty
  a_busy: assert property (p_busy) else $error("table busy length wrong");
  property p_lat; taken |-> ##9 (dataWrite.valid && dataWrite.addr == $past(tableReq.dest, 9)); endproperty
  a_lat: assert property (p_lat) else $error("table result late or misdirected");
  property p_pulse; dataWrite.valid |=> !dataWrite.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("data write longer than one cycle");
  property p_thb; !dataWrite.valid |-> $stable(tableHighByte); endproperty
  a_thb: assert property (p_thb) else $error("high byte changed off a table read");
  property p_thb_bus; thbRd |=> wb_ack_o && wb_dat_o == {24'h0, tableHighByte}; endproperty
  a_thb_bus: assert property (p_thb_bus) else $error("high byte read mismatch");
  property p_inc; fetch |=> pcValue == 10'($past(pcValue) + 10'h1); endproperty
  a_inc: assert property (p_inc) else $error("pc did not step by one");
  property p_stall; tableBusy && !pcWr |=> $stable(pcValue); endproperty
  a_stall: assert property (p_stall) else $error("pc moved during table read");
  property p_oe; !progEnable ##1 !progEnable |-> prog_serial_data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("programming pin driven while off");
  c_full: cover property (taken && !tableReq.lastPage);
  c_last: cover property (taken && tableReq.lastPage);
  c_thb: cover property (thbRd);
endmodule
bind pmt_prog_mem pmt_monitor mon (.*);
`default_nettype wire

//--- dv/pmt_core_model.sv
/* core model: issues one table read per go pulse.
   assumes the memory block supplies instrTick and tableBusy. */
`timescale 1ns/100ps
`default_nettype none
module pmt_core_model
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic instrTick,
  input wire logic tableBusy,
  input wire logic go,
  input wire logic lastPage,
  input wire logic [7:0] dest,
  output pmt_pkg::pmt_tblreq_t tableReq
);
  import pmt_pkg::*;
  always @(posedge clock) begin
    if (!nrst)
      tableReq <= '0;
    else if (go && !tableReq.valid)
      tableReq <= '{1'b1, lastPage, dest};
    else if (instrTick && !tableBusy)
      tableReq.valid <= 1'b0;
  end
endmodule
`default_nettype wire

//--- dv/tb_program_memory_table_read.sv
/* bench: registers, serial loading and table reads.
   assumes the core model and the checker bind. */
`timescale 1ns/100ps
`default_nettype none
module tb_program_memory_table_read;
  import pmt_pkg::*;
  logic clock = 0, nrst = 0, wbCyc = 0, wbWe = 0, go = 0, lastPage = 0;
  logic progEnable = 0, sck = 0, sdo = 0, ack, busy, tick, progOut, progOe_n;
  logic [3:0] wbSel = 4'h1;
  logic jump = 0;
  logic [9:0] jumpT = 10'h000;
  logic [7:0] wbAdr = 8'h00, dest = 8'h00, thb;
  logic [31:0] wbDat = 32'h0, wbOut, rd;
  logic [15:0] instr;
  logic [9:0] pc;
  pmt_tblreq_t tableReq;
  pmt_dmwr_t dataWrite;
  int err_total = 0, n_tests = 0, cycles = 0;
  wire logic pinLevel = progOe_n ? sdo : progOut;
  pmt_prog_mem #(.WORD_W(14)) uut (.clock(clock), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbOut),
    .wb_ack_o(ack), .instrTick(tick), .instrWord(instr), .pcValue(pc), .jumpReq(jump),
    .jumpTarget(jumpT), .tableReq(tableReq), .tableBusy(busy), .dataWrite(dataWrite),
    .tableHighByte(thb), .progEnable(progEnable), .prog_serial_clock(sck),
    .prog_serial_data_in(pinLevel), .prog_serial_data_out(progOut), .prog_serial_data_oe_n(progOe_n),
    .debugEnable(1'b0), .debug_serial_clock(1'b0), .debug_serial_data_in(1'b1),
    .debug_serial_data_out(), .debug_serial_data_oe_n());
  pmt_core_model core (.clock(clock), .nrst(nrst), .instrTick(tick), .tableBusy(busy), .go(go),
    .lastPage(lastPage), .dest(dest), .tableReq(tableReq));
  initial forever #2 clock = ~clock;
  // ==========
  // tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    wbCyc <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do @(posedge clock); while (ack !== 1'b1);
    rd = wbOut;
    wbCyc <= 1'b0;
    @(posedge clock);
  endtask
  // the clock stands still between frames; edges are two clocks apart
  task automatic ser_wr(logic [9:0] a, logic [15:0] d);
    logic [26:0] f;
    f = {PMT_CMD_WRITE, a, d};
    progEnable <= 1'b1;
    for (int i = 26; i >= 0; i--) begin
      sdo <= f[i];
      repeat (2) @(posedge clock);
      sck <= 1'b1;
      repeat (2) @(posedge clock);
      sck <= 1'b0;
    end
    @(posedge clock);
  endtask
  task automatic tbl(logic lp, logic [7:0] d, logic [7:0] lo, logic [7:0] hi);
    int n;
    n = 0;
    lastPage <= lp;
    dest <= d;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (dataWrite.valid !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check("latency", 32'd8, 32'(n));
    check("dest", {24'h0, d}, {24'h0, dataWrite.addr});
    check("low byte", {24'h0, lo}, {24'h0, dataWrite.data});
    check("high byte", {24'h0, hi}, {24'h0, thb});
    wb(1'b0, PMT_REG_TBL_HIGH, 32'h0, 4'h1);
    check("high byte reg", {24'h0, hi}, rd);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    check("pc", 32'h0, {22'h0, pc});
    check("high byte", 32'h0, {24'h0, thb});
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wb(1'b1, PMT_REG_PTR_LOW, 32'h06, 4'h1);
    wb(1'b1, PMT_REG_PTR_LOW, 32'h55, 4'he);
    wb(1'b0, PMT_REG_PTR_LOW, 32'h0, 4'h1);
    check("ptr low", 32'h06, rd);
    wb(1'b1, PMT_REG_TBL_HIGH, 32'hff, 4'h1);
    wb(1'b0, PMT_REG_TBL_HIGH, 32'h0, 4'h1);
    check("high byte ro", 32'h0, rd);
    wb(1'b0, 8'h40, 32'h0, 4'h1);
    check("unmapped", 32'h0, rd);
    $display("t_regs done");
  endtask
  // last word and its page-zero twin tell the address sources apart
  task automatic t_table;
    ser_wr(10'h3ff, 16'hff5c);
    ser_wr(10'h0ff, 16'h0012);
    wb(1'b1, PMT_REG_PTR_LOW, 32'hff, 4'h1);
    wb(1'b1, PMT_REG_PTR_HIGH, 32'h03, 4'h1);
    tbl(1'b0, 8'h21, 8'h5c, 8'h3f);
    tbl(1'b0, 8'h22, 8'h5c, 8'h3f);
    wb(1'b1, PMT_REG_PTR_HIGH, 32'h00, 4'h1);
    tbl(1'b0, 8'h23, 8'h12, 8'h00);
    tbl(1'b1, 8'h24, 8'h5c, 8'h3f);
    $display("t_table done");
  endtask
  // jump onto the last word, then the fetch there and the wrap to zero
  task automatic t_jump;
    jumpT <= 10'h3ff;
    jump <= 1'b1;
    do @(posedge clock); while (tick !== 1'b1);
    jump <= 1'b0;
    @(posedge clock);
    check("pc jump", 32'h3ff, {22'h0, pc});
    do @(posedge clock); while (tick !== 1'b1);
    @(posedge clock);
    check("fetch", 32'h3f5c, {16'h0, instr});
    check("pc wrap", 32'h0, {22'h0, pc});
    $display("t_jump done");
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset;
    t_regs;
    t_table;
    t_jump;
    wrap_up;
  end
endmodule
`default_nettype wire
